//--- clmt_regs.svh
/*
 * register offsets, field positions, reset values and timing counts
 * for the charger limit, monitor and timer register bank.
 * assumes inclusion by bare name from the design files.
 */
`ifndef CLMT_REGS_SVH
`define CLMT_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define CLMT_OFS_LIMIT 8'h09
`define CLMT_OFS_MON 8'h0a
`define CLMT_OFS_FLOOR 8'h0b

// ****************************************
// reset values and field positions
// ****************************************
`define CLMT_RST_LIMIT 8'h0a
`define CLMT_RST_FLOOR 8'h4a
`define CLMT_RST_MON 8'h00
`define CLMT_LIMIT_WMASK 8'h3f
`define CLMT_FLOOR_WMASK 8'hfe
`define CLMT_BIT_SOFTRST 7
`define CLMT_BIT_MEASREQ 7
`define CLMT_BAND_TOP 2'h3
`define CLMT_STEP_NONE 3'h0

// ****************************************
// timing
// ****************************************
`define CLMT_CLK_HZ 50000000
`define CLMT_SETTLE_NS 1000
`define CLMT_SETTLE_CYC ((`CLMT_SETTLE_NS * (`CLMT_CLK_HZ / 1000000) + 999) / 1000)

`endif

//--- clmt_pkg.sv
/*
 * types shared by the charger register bank.
 * assumes nothing beyond a single clock domain.
 */
package clmt_pkg;

    typedef enum logic [1:0] {
        CLMT_IDLE = 2'b00,
        CLMT_SETTLE = 2'b01,
        CLMT_SAMPLE = 2'b10
    } clmt_mon_e;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } clmt_bus_s;

    typedef struct packed {
        logic [2:0] inputCurrentCapCode;
        logic [2:0] batteryLockoutThreshold;
        logic lockoutDisabled;
        logic [2:0] lockoutVoltageSel;
        logic inputFloorEnable;
        logic [2:0] inputVoltageFloorCode;
        logic timerHalfRate;
        logic [1:0] safetyTimerSelect;
        logic safetyTimerDisabled;
    } clmt_cfg_s;

endpackage : clmt_pkg

//--- clmt_monitor.sv
/*
 * battery monitor search: top band downward until a step result is seen.
 * assumes the comparator result input is already in the core_clk domain.
 */
`include "clmt_regs.svh"

module clmt_monitor (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [2:0] stepResult,
    output logic [1:0] bandTry,
    output logic done,
    output logic [1:0] bandOut,
    output logic [2:0] stepOut
);

    typedef struct packed {
        clmt_pkg::clmt_mon_e st;
        logic [7:0] cnt;
        logic [1:0] band;
        logic done;
        logic [1:0] bandRes;
        logic [2:0] stepRes;
    } clmt_mstate_s;

    clmt_mstate_s s_q;
    clmt_mstate_s s_d;

    localparam logic [7:0] SETTLE_CYC = 8'(`CLMT_SETTLE_CYC);

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        case (s_q.st)
            clmt_pkg::CLMT_IDLE: begin
                if (start) begin
                    s_d.st = clmt_pkg::CLMT_SETTLE;
                    s_d.band = `CLMT_BAND_TOP;
                    s_d.cnt = SETTLE_CYC;
                end
            end
            clmt_pkg::CLMT_SETTLE: begin
                if (s_q.cnt <= 8'h01) begin
                    s_d.st = clmt_pkg::CLMT_SAMPLE;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            clmt_pkg::CLMT_SAMPLE: begin
                if (stepResult != `CLMT_STEP_NONE) begin
                    s_d.st = clmt_pkg::CLMT_IDLE;
                    s_d.done = 1'b1;
                    s_d.bandRes = s_q.band;
                    s_d.stepRes = stepResult;
                end else if (s_q.band == 2'h0) begin
                    s_d.st = clmt_pkg::CLMT_IDLE;
                    s_d.done = 1'b1;
                    s_d.bandRes = 2'h0;
                    s_d.stepRes = `CLMT_STEP_NONE;
                end else begin
                    s_d.band = s_q.band - 2'h1;
                    s_d.cnt = SETTLE_CYC;
                    s_d.st = clmt_pkg::CLMT_SETTLE;
                end
            end
            default: begin
                s_d.st = clmt_pkg::CLMT_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bandTry = s_q.band;
    assign done = s_q.done;
    assign bandOut = s_q.bandRes;
    assign stepOut = s_q.stepRes;

    a_search_starts_top: assert property (@(posedge core_clk) disable iff (srst)
        (s_q.st == clmt_pkg::CLMT_IDLE && start) |=> (s_q.band == 2'h3))
        else $error("search did not start at top band");
    a_step_down: assert property (@(posedge core_clk) disable iff (srst)
        (s_q.st == clmt_pkg::CLMT_SAMPLE && stepResult == `CLMT_STEP_NONE && s_q.band != 2'h0)
        |=> (s_q.st == clmt_pkg::CLMT_SETTLE && s_q.band == $past(s_q.band) - 2'h1))
        else $error("search did not step down a band");
    a_stop_on_hit: assert property (@(posedge core_clk) disable iff (srst)
        (s_q.st == clmt_pkg::CLMT_SAMPLE && stepResult != `CLMT_STEP_NONE)
        |=> (done && stepOut == $past(stepResult) && bandOut == $past(s_q.band)))
        else $error("search did not stop on first step result");

endmodule // clmt_monitor

//--- clmt_bank.sv
/*
 * charger limit, monitor and timer register bank at offsets 09h..0bh.
 * assumes a register access port already decoded from the serial slave,
 * same clock; the cap resistor pin and both cap code inputs pass two flops here.
 */
// Functional notes
// - writing one to limit register bit 7 restores all defaults; reads zero.
// - input current cap is 50 mA plus code times 50 mA.
// - default cap code from resistor pin, or from otp when pin grounded.
// - lockout codes 0-2 give 3 V, down to 2.2 V; 111 disables.
// - writing one to monitor bit 7 starts a measurement; reads zero.
// - band field reports 60-100 percent bands of regulation voltage.
// - step field reports position inside the reported band.
// - search starts at top band, steps down while step result is zero.
// - no band hits gives band 00 and step 000.
// - floor is 4.2 V plus code times 100 mV; bit 7 high disables.
// - half-rate bit slows safety timer outside cc and cv.
// - timer field selects 30 min, 3 h, 9 h or disabled.
// - limit register resets to 0000 1010.
// - floor and timer register resets to 0100 1010.
// - serial use runs from internal defaults until host writes.
`include "clmt_regs.svh"

module clmt_bank (
    input wire logic core_clk,
    input wire logic srst,
    input clmt_pkg::clmt_bus_s bus,
    output logic [7:0] rdata,
    output logic rvalid,
    input wire logic currentCapResistorPin,
    input wire logic [2:0] resistorCapCode,
    input wire logic [2:0] otpCapCode,
    input wire logic lowPowerEntry,
    input wire logic [2:0] monitorStepResult,
    input wire logic chargeInCcCv,
    output logic [1:0] monitorBandTry,
    output clmt_pkg::clmt_cfg_s cfg,
    output logic timerTick
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0] limitReg;
        logic [7:0] monReg;
        logic [7:0] floorReg;
        logic [7:0] rdata;
        logic rvalid;
        logic pinSync1;
        logic pinSync2;
        logic [2:0] capSync1;
        logic [2:0] capSync2;
        logic [2:0] otpSync1;
        logic [2:0] otpSync2;
        logic hostWritten;
        logic start;
        logic divPhase;
        logic tick;
        logic [1:0] bandTry;
        clmt_pkg::clmt_cfg_s cfg;
    } clmt_state_s;

    clmt_state_s s_q;
    clmt_state_s s_d;
    localparam logic [7:0] RST_LIMIT = `CLMT_RST_LIMIT;
    localparam logic [7:0] RST_FLOOR = `CLMT_RST_FLOOR;

    logic [1:0] monBandTry;
    logic monDone;
    logic [1:0] monBand;
    logic [2:0] monStep;
    logic [2:0] defaultCap;

    clmt_monitor u_monitor (
        .core_clk(core_clk),
        .srst(srst),
        .start(s_q.start),
        .stepResult(monitorStepResult),
        .bandTry(monBandTry),
        .done(monDone),
        .bandOut(monBand),
        .stepOut(monStep)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.start = 1'b0;
        s_d.tick = 1'b0;
        s_d.bandTry = monBandTry;
        // ****************************************
        // pin synchronisers and default cap code
        // ****************************************
        // codes are static straps; a code changing mid-flight may tear for a cycle
        s_d.pinSync1 = currentCapResistorPin;
        s_d.pinSync2 = s_q.pinSync1;
        s_d.capSync1 = resistorCapCode;
        s_d.capSync2 = s_q.capSync1;
        s_d.otpSync1 = otpCapCode;
        s_d.otpSync2 = s_q.otpSync1;
        // grounded resistor pin means otp default
        defaultCap = s_q.pinSync2 ? s_q.capSync2 : s_q.otpSync2;
        // follow the pin-derived cap code until the host writes it
        if (!s_q.hostWritten) begin
            s_d.limitReg[5:3] = defaultCap;
        end
        // ****************************************
        // register writes
        // ****************************************
        if (bus.wrEn) begin
            case (bus.addr)
                `CLMT_OFS_LIMIT: begin
                    if (bus.wdata[`CLMT_BIT_SOFTRST]) begin
                        s_d.limitReg = `CLMT_RST_LIMIT;
                        s_d.floorReg = `CLMT_RST_FLOOR;
                        s_d.monReg = `CLMT_RST_MON;
                        s_d.hostWritten = 1'b0;
                    end else begin
                        s_d.limitReg = bus.wdata & `CLMT_LIMIT_WMASK;
                        s_d.hostWritten = 1'b1;
                    end
                end
                `CLMT_OFS_MON: begin
                    if (bus.wdata[`CLMT_BIT_MEASREQ]) begin
                        s_d.start = 1'b1;
                    end
                end
                `CLMT_OFS_FLOOR: begin
                    s_d.floorReg = bus.wdata & `CLMT_FLOOR_WMASK;
                end
                default: begin
                end
            endcase
        end
        if (lowPowerEntry) begin
            s_d.start = 1'b1;
        end
        // ****************************************
        // monitor result and read mux
        // ****************************************
        // result lands after the write or low-power entry that started it; result wins the cycle
        if (monDone) begin
            s_d.monReg = {1'b0, monBand, monStep, 2'b00};
        end
        s_d.rdata = 8'h00;
        if (bus.rdEn) begin
            s_d.rvalid = 1'b1;
            case (bus.addr)
                `CLMT_OFS_LIMIT: s_d.rdata = {1'b0, 1'b0, s_q.limitReg[5:0]};
                `CLMT_OFS_MON: s_d.rdata = {1'b0, s_q.monReg[6:2], 2'b00};
                `CLMT_OFS_FLOOR: s_d.rdata = {s_q.floorReg[7:1], 1'b0};
                default: s_d.rdata = 8'h00;
            endcase
        end
        // ****************************************
        // decoded config outputs
        // ****************************************
        s_d.cfg.inputCurrentCapCode = s_q.limitReg[5:3];
        s_d.cfg.batteryLockoutThreshold = s_q.limitReg[2:0];
        s_d.cfg.lockoutDisabled = (s_q.limitReg[2:0] == 3'h7);
        case (s_q.limitReg[2:0])
            3'h0, 3'h1, 3'h2: s_d.cfg.lockoutVoltageSel = 3'h0;
            3'h3: s_d.cfg.lockoutVoltageSel = 3'h1;
            3'h4: s_d.cfg.lockoutVoltageSel = 3'h2;
            3'h5: s_d.cfg.lockoutVoltageSel = 3'h3;
            3'h6: s_d.cfg.lockoutVoltageSel = 3'h4;
            default: s_d.cfg.lockoutVoltageSel = 3'h7;
        endcase
        s_d.cfg.inputFloorEnable = ~s_q.floorReg[7];
        s_d.cfg.inputVoltageFloorCode = s_q.floorReg[6:4];
        s_d.cfg.timerHalfRate = s_q.floorReg[3];
        s_d.cfg.safetyTimerSelect = s_q.floorReg[2:1];
        s_d.cfg.safetyTimerDisabled = (s_q.floorReg[2:1] == 2'h3);
        // ****************************************
        // safety timer enable
        // ****************************************
        // half-rate tick outside cc/cv when floor bit 3 is set, full rate otherwise; timer code 11 stops it
        s_d.divPhase = ~s_q.divPhase;
        if (s_q.floorReg[3] && !chargeInCcCv) begin
            s_d.tick = s_q.divPhase;
        end else begin
            s_d.tick = 1'b1;
        end
        if (s_q.floorReg[2:1] == 2'h3) begin
            s_d.tick = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.limitReg <= `CLMT_RST_LIMIT;
            s_q.floorReg <= `CLMT_RST_FLOOR;
            s_q.monReg <= `CLMT_RST_MON;
            // decode of the reset values, so cfg is right during reset too
            s_q.cfg.inputCurrentCapCode <= RST_LIMIT[5:3];
            s_q.cfg.batteryLockoutThreshold <= RST_LIMIT[2:0];
            s_q.cfg.inputFloorEnable <= ~RST_FLOOR[7];
            s_q.cfg.inputVoltageFloorCode <= RST_FLOOR[6:4];
            s_q.cfg.timerHalfRate <= RST_FLOOR[3];
            s_q.cfg.safetyTimerSelect <= RST_FLOOR[2:1];
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign rvalid = s_q.rvalid;
    assign cfg = s_q.cfg;
    assign timerTick = s_q.tick;
    assign monitorBandTry = s_q.bandTry;

    // ****************************************
    // checks
    // ****************************************
    a_softrst_defaults: assert property (@(posedge core_clk) disable iff (srst)
        (bus.wrEn && bus.addr == `CLMT_OFS_LIMIT && bus.wdata[7]) |=> (s_q.floorReg == 8'h4a))
        else $error("soft reset did not restore floor register");
    a_limit_bit7_zero: assert property (@(posedge core_clk) disable iff (srst)
        (bus.rdEn && bus.addr == `CLMT_OFS_LIMIT) |=> (rvalid && !rdata[7] && !rdata[6]))
        else $error("limit register top bits read non-zero");
    a_mon_req_zero: assert property (@(posedge core_clk) disable iff (srst)
        (bus.rdEn && bus.addr == `CLMT_OFS_MON) |=> (!rdata[7] && rdata[1:0] == 2'b00))
        else $error("monitor request bit read non-zero");
    a_mon_start: assert property (@(posedge core_clk) disable iff (srst)
        (bus.wrEn && bus.addr == `CLMT_OFS_MON && bus.wdata[7]) |=> s_q.start)
        else $error("measure request did not start search");
    a_floor_enable: assert property (@(posedge core_clk) disable iff (srst)
        ##1 (cfg.inputFloorEnable == !$past(s_q.floorReg[7])))
        else $error("floor enable polarity wrong");
    a_lockout_dis: assert property (@(posedge core_clk) disable iff (srst)
        (s_q.limitReg[2:0] == 3'h7) [*2] |-> cfg.lockoutDisabled)
        else $error("lockout code 7 not decoded as disabled");
    a_half_rate: assert property (@(posedge core_clk) disable iff (srst)
        (timerTick && s_q.floorReg[3] && !chargeInCcCv && $stable(s_q.floorReg)
         && $past(s_q.floorReg[3] && !chargeInCcCv)) |=> !timerTick || chargeInCcCv)
        else $error("timer not at half rate");
    a_timer_off: assert property (@(posedge core_clk) disable iff (srst)
        (s_q.floorReg[2:1] == 2'h3) |=> !timerTick)
        else $error("timer ticking while disabled");
    a_no_hit_zero: assert property (@(posedge core_clk) disable iff (srst)
        (monDone && monStep == 3'h0) |=> (s_q.monReg[6:2] == 5'h00))
        else $error("no-hit result not zero");
    a_unused_zero: assert property (@(posedge core_clk) disable iff (srst)
        (bus.rdEn && bus.addr == `CLMT_OFS_FLOOR) |=> !rdata[0])
        else $error("unused floor bit reads non-zero");
    a_softrst_limit: assert property (@(posedge core_clk) disable iff (srst)
        (bus.wrEn && bus.addr == `CLMT_OFS_LIMIT && bus.wdata[7])
        |=> (s_q.limitReg == `CLMT_RST_LIMIT && !s_q.hostWritten))
        else $error("soft reset did not restore limit register");
    a_limit_write: assert property (@(posedge core_clk) disable iff (srst)
        (bus.wrEn && bus.addr == `CLMT_OFS_LIMIT && !bus.wdata[7])
        |=> (s_q.limitReg == ($past(bus.wdata) & `CLMT_LIMIT_WMASK)))
        else $error("limit write without reset bit not stored");
    a_read_unmapped: assert property (@(posedge core_clk) disable iff (srst)
        (bus.rdEn && (bus.addr < `CLMT_OFS_LIMIT || bus.addr > `CLMT_OFS_FLOOR)) |=> (rvalid && rdata == 8'h00))
        else $error("unmapped offset read non-zero");
    a_result_lands: assert property (@(posedge core_clk) disable iff (srst)
        monDone |=> (s_q.monReg == {1'b0, $past(monBand), $past(monStep), 2'b00}))
        else $error("monitor result not stored");

    // ****************************************
    // checks: default cap and reset
    // ****************************************
    a_reset_limit: assert property (@(posedge core_clk)
        $fell(srst) |-> (s_q.limitReg == `CLMT_RST_LIMIT))
        else $error("limit register reset value wrong");
    a_reset_floor: assert property (@(posedge core_clk)
        $fell(srst) |-> (s_q.floorReg == `CLMT_RST_FLOOR))
        else $error("floor register reset value wrong");
    a_default_follow: assert property (@(posedge core_clk) disable iff (srst)
        (!s_q.hostWritten && !(bus.wrEn && bus.addr == `CLMT_OFS_LIMIT)) |=> (s_q.limitReg[5:3] == $past(defaultCap)))
        else $error("cap code not following pin default");
    a_host_holds: assert property (@(posedge core_clk) disable iff (srst)
        (s_q.hostWritten && !(bus.wrEn && bus.addr == `CLMT_OFS_LIMIT)) |=> $stable(s_q.limitReg))
        else $error("host-written limit register changed");

    // ****************************************
    // checks: decode and timer
    // ****************************************
    a_cap_code_map: assert property (@(posedge core_clk) disable iff (srst)
        ##1 (cfg.inputCurrentCapCode == $past(s_q.limitReg[5:3])))
        else $error("cap code output wrong");
    a_lockout_map: assert property (@(posedge core_clk) disable iff (srst)
        (s_q.limitReg[2:0] == 3'h3) [*2] |-> (cfg.lockoutVoltageSel == 3'h1))
        else $error("lockout code 3 decoded wrong");
    a_floor_code: assert property (@(posedge core_clk) disable iff (srst)
        ##1 (cfg.inputVoltageFloorCode == $past(s_q.floorReg[6:4])))
        else $error("floor code output wrong");
    a_timer_sel: assert property (@(posedge core_clk) disable iff (srst)
        ##1 (cfg.safetyTimerSelect == $past(s_q.floorReg[2:1])))
        else $error("timer select output wrong");
    a_full_rate: assert property (@(posedge core_clk) disable iff (srst)
        (!s_q.floorReg[3] && s_q.floorReg[2:1] != 2'h3) |=> timerTick)
        else $error("timer slowed while half rate off");

endmodule // clmt_bank

//--- clmt_host_model.sv
/*
 * host model for the charger register bank: register access tasks and a
 * battery comparator that answers for the band under trial.
 * assumes the bank takes requests on the rising edge of core_clk.
 */
module clmt_host_model (
    input wire logic core_clk,
    output clmt_pkg::clmt_bus_s bus,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic [1:0] bandTry,
    input wire logic [1:0] batBand,
    input wire logic [2:0] batStep,
    output logic [2:0] stepResult
);
    timeunit 1ns;
    timeprecision 1ps;

    initial bus = '0;

    // ****************************************
    // comparator: bands above the battery see nothing, bands below see full scale
    // ****************************************
    always_comb begin
        if (bandTry > batBand) begin
            stepResult = 3'h0;
        end else if (bandTry == batBand) begin
            stepResult = batStep;
        end else begin
            stepResult = 3'h7;
        end
    end

    // ****************************************
    // register access
    // ****************************************
    // address and data flip after release so stale values are never relied on
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        bus.wrEn = 1'b1;
        bus.addr = a;
        bus.wdata = d;
        @(negedge core_clk);
        bus.wrEn = 1'b0;
        bus.addr = ~a;
        bus.wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(negedge core_clk);
        bus.rdEn = 1'b1;
        bus.addr = a;
        @(negedge core_clk);
        bus.rdEn = 1'b0;
        bus.addr = ~a;
        for (int i = 0; i < 4 && ok !== 1'b1; i++) begin
            if (rvalid === 1'b1) begin
                d = rdata;
                ok = 1'b1;
            end else begin
                @(negedge core_clk);
            end
        end
    endtask
endmodule // clmt_host_model

//--- testbench.sv
/*
 * self-checking bench for the charger register bank.
 * assumes the host model drives the access port and answers the monitor.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk, srst, pinFitted, lowPowerEntry, chargeInCcCv, timerTick, rvalid;
    logic [2:0] resCode, otpCode, stepResult, batStep;
    logic [1:0] bandTry, batBand;
    logic [7:0] rdata, w, v;
    logic [31:0] seed = 32'd92;
    clmt_pkg::clmt_bus_s bus;
    clmt_pkg::clmt_cfg_s cfg;
    int failures = 0;
    int cmp_count = 0;
    logic [1:0] bandTab [8] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h2, 2'h0, 2'h0, 2'h0};
    logic [2:0] stepTab [8] = '{3'h7, 3'h1, 3'h6, 3'h3, 3'h0, 3'h0, 3'h2, 3'h1};

    clmt_host_model i_host (.core_clk(core_clk), .bus(bus), .rdata(rdata), .rvalid(rvalid),
        .bandTry(bandTry), .batBand(batBand), .batStep(batStep), .stepResult(stepResult));

    clmt_bank i_dut (.core_clk(core_clk), .srst(srst), .bus(bus), .rdata(rdata), .rvalid(rvalid),
        .currentCapResistorPin(pinFitted), .resistorCapCode(resCode), .otpCapCode(otpCode),
        .lowPowerEntry(lowPowerEntry), .monitorStepResult(stepResult), .chargeInCcCv(chargeInCcCv),
        .monitorBandTry(bandTry), .cfg(cfg), .timerTick(timerTick));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // a band whose step is zero falls through to full scale one band lower
    function automatic logic [7:0] mon_exp(input logic [1:0] b, input logic [2:0] s);
        if (s != 3'h0) return {1'b0, b, s, 2'b00};
        if (b == 2'h0) return 8'h00;
        return {1'b0, b - 2'h1, 3'h7, 2'b00};
    endfunction

    // lockout selector: codes 0-2 share the top step, 7 is off
    function automatic logic [7:0] lockout_exp(input logic [2:0] c);
        if (c < 3'h3) return 8'h00;
        if (c == 3'h7) return 8'h07;
        return {5'h0, c - 3'h2};
    endfunction

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        i_host.rd(a, d, ok);
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t ns: got %h expected %h", $time, 8'h00, 8'h01);
            test_done();
        end else begin
            cmp(d, exp);
        end
    endtask

    task automatic chk_cfg(input logic [7:0] got, input logic [7:0] exp);
        cmp(got, exp);
    endtask

    task automatic tick_count(input logic [7:0] tmr, input logic cccv, input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        i_host.wr(8'h0b, tmr);
        chargeInCcCv = cccv;
        repeat (4) @(negedge core_clk);
        for (int k = 0; k < 40; k++) begin
            @(negedge core_clk);
            if (timerTick === 1'b1) n++;
        end
        chk_cfg(n, exp);
    endtask

    // ****************************************
    // clock and watchdog
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        $display("mismatch at %0t ns: got %h expected %h", $time, 8'h00, 8'h01);
        test_done();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        srst = 1'b1;
        pinFitted = 1'b1;
        resCode = 3'h1;
        otpCode = 3'h6;
        lowPowerEntry = 1'b0;
        chargeInCcCv = 1'b0;
        batBand = 2'h3;
        batStep = 3'h1;
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        repeat (5) @(negedge core_clk);
        chk_reg(8'h09, 8'h0a);
        chk_reg(8'h0b, 8'h4a);
        chk_reg(8'h0a, 8'h00);
        chk_reg(8'h0c, 8'h00);
        $display("test defaults done");
        for (int i = 0; i < 8; i++) begin
            w = 8'(rnd());
            w[7] = 1'b0;
            w[2:0] = i[2:0];
            v = 8'(rnd());
            v[2:1] = i[1:0];
            i_host.wr(8'h09, w);
            i_host.wr(8'h0b, v);
            chk_reg(8'h09, w & 8'h3f);
            chk_reg(8'h0b, v & 8'hfe);
            chk_cfg({5'h0, cfg.inputCurrentCapCode}, {5'h0, w[5:3]});
            chk_cfg({5'h0, cfg.batteryLockoutThreshold}, {5'h0, w[2:0]});
            chk_cfg({7'h0, cfg.lockoutDisabled}, {7'h0, w[2:0] == 3'h7});
            chk_cfg({5'h0, cfg.lockoutVoltageSel}, lockout_exp(w[2:0]));
            chk_cfg({7'h0, cfg.inputFloorEnable}, {7'h0, ~v[7]});
            chk_cfg({5'h0, cfg.inputVoltageFloorCode}, {5'h0, v[6:4]});
            chk_cfg({7'h0, cfg.timerHalfRate}, {7'h0, v[3]});
            chk_cfg({6'h0, cfg.safetyTimerSelect}, {6'h0, v[2:1]});
            chk_cfg({7'h0, cfg.safetyTimerDisabled}, {7'h0, v[2:1] == 2'h3});
        end
        $display("test field decode done");
        i_host.wr(8'h09, 8'h3b);
        resCode = 3'h5;
        repeat (5) @(negedge core_clk);
        chk_reg(8'h09, 8'h3b);
        i_host.wr(8'h09, 8'h80);
        repeat (5) @(negedge core_clk);
        chk_reg(8'h09, 8'h2a);
        chk_reg(8'h0b, 8'h4a);
        pinFitted = 1'b0;
        repeat (5) @(negedge core_clk);
        chk_reg(8'h09, 8'h32);
        $display("test soft reset done");
        i_host.wr(8'h0a, 8'h7f);
        repeat (5) @(negedge core_clk);
        chk_reg(8'h0a, 8'h00);
        for (int i = 0; i < 8; i++) begin
            w = 8'(rnd());
            batBand = (i > 5) ? w[1:0] : bandTab[i];
            batStep = stepTab[i];
            if (i[0]) begin
                i_host.wr(8'h0a, 8'h80);
            end else begin
                @(negedge core_clk);
                lowPowerEntry = 1'b1;
                @(negedge core_clk);
                lowPowerEntry = 1'b0;
            end
            repeat (260) @(negedge core_clk);
            chk_reg(8'h0a, mon_exp(batBand, batStep));
        end
        $display("test monitor search done");
        tick_count(8'h0a, 1'b0, 8'd20);
        tick_count(8'h0a, 1'b1, 8'd40);
        tick_count(8'h02, 1'b0, 8'd40);
        tick_count(8'h0e, 1'b0, 8'd0);
        $display("test safety timer done");
        srst = 1'b1;
        repeat (3) @(negedge core_clk);
        srst = 1'b0;
        repeat (5) @(negedge core_clk);
        chk_reg(8'h0b, 8'h4a);
        chk_reg(8'h09, 8'h32);
        $display("test mid-run reset done");
        test_done();
    end
endmodule // testbench
